// *** common/sbc_int_wake_pkg.sv ***
`default_nettype none
package sbc_int_wake_pkg;
    localparam int          REG_W         = 16;
    localparam int          SPI_BITS      = 16;
    localparam logic [4:0]  SPI_BITS_C    = 5'h10;
    localparam logic [4:0]  ADDR_BITS_C   = 5'h03;
    localparam logic [2:0]  ADDR_INT_CTRL = 3'h2;
    localparam logic [2:0]  ADDR_INT_STAT = 3'h3;
    // control register field positions
    localparam int          RO_BIT        = 12;
    localparam int          CORE_UV_EN    = 11;
    localparam int          CAN_UV_EN     = 10;
    localparam int          WAKE_A_SEL    = 6;
    localparam int          WAKE_B_SEL    = 4;
    localparam int          CAN_LP_BIT    = 3;
    localparam int          RTH_BIT       = 2;
    localparam int          WAKE_A_SMP    = 1;
    localparam int          WAKE_B_SMP    = 0;
    localparam logic [15:0] CTRL_WMASK    = 16'h0cff;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    // status register field positions
    localparam int          ST_CORE_UV    = 11;
    localparam int          ST_CAN_UV     = 10;
    localparam int          ST_WAKE_A     = 6;
    localparam int          ST_WAKE_B     = 4;
    localparam int          ST_CAN_WAKE   = 3;
    localparam logic [15:0] STAT_MASK     = 16'h0c58;
    localparam logic [15:0] STAT_RESET    = 16'h0000;
    // edge select codes
    localparam logic [1:0]  EDGE_OFF      = 2'h0;
    localparam logic [1:0]  EDGE_RISE     = 2'h1;
    localparam logic [1:0]  EDGE_FALL     = 2'h2;
    localparam logic [1:0]  EDGE_BOTH     = 2'h3;
    // chip mode codes
    localparam logic [1:0]  MODE_STANDBY  = 2'h0;
    localparam logic [1:0]  MODE_SLEEP    = 2'h1;
    localparam logic [1:0]  MODE_NORM_OFF = 2'h2;
    localparam logic [1:0]  MODE_NORM_ON  = 2'h3;
    // transceiver mode codes
    localparam logic [1:0]  CAN_OFF       = 2'h0;
    localparam logic [1:0]  CAN_ACTIVE    = 2'h1;
    localparam logic [1:0]  CAN_LOWPOWER  = 2'h2;
    // timing
    localparam int          CLK_PERIOD_NS = 8;
    localparam int          CLK_FREQ_KHZ  = 125000;
    localparam int          SMP_SHORT_MS  = 16;
    localparam int          SMP_LONG_MS   = 64;
    localparam int          BIAS_ON_NS    = 10000;
    localparam logic [23:0] SMP_SHORT_CYC = 24'(SMP_SHORT_MS * CLK_FREQ_KHZ);
    localparam logic [23:0] SMP_LONG_CYC  = 24'(SMP_LONG_MS * CLK_FREQ_KHZ);
    localparam logic [23:0] BIAS_ON_CYC   = 24'((BIAS_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // synchroniser lanes
    localparam int          SY_SCK        = 0;
    localparam int          SY_CS         = 1;
    localparam int          SY_SDI        = 2;
    localparam int          SY_CORE_UV    = 3;
    localparam int          SY_CAN_UV     = 4;
    localparam int          SY_CAN_WAKE   = 5;
    localparam int          SY_WAKE_A     = 6;
    localparam int          SY_WAKE_B     = 7;
endpackage
`default_nettype wire

// *** src/sbc_interrupt_wake_control.sv ***
`timescale 1ns/10ps
`default_nettype none
module sbc_interrupt_wake_control #(
    parameter logic [23:0] SHORT_PERIOD_CYC = sbc_int_wake_pkg::SMP_SHORT_CYC,
    parameter logic [23:0] LONG_PERIOD_CYC  = sbc_int_wake_pkg::SMP_LONG_CYC
) (
    input  wire logic       ref_clk_in,                 // 125 MHz
    input  wire logic       reset_in,                   // sync, active high
    input  wire logic       spi_sck_in,                 // spi clock pin
    input  wire logic       spi_cs_n_in,                // spi select, low active
    input  wire logic       spi_sdi_in,                 // spi data in
    output logic            spi_sdo_out,                // spi data out
    output logic            spi_sdo_oe_n_out,           // low while sdo driven
    input  wire logic [1:0] chip_mode_field_in,         // mode from mode register
    input  wire logic       wake_bias_control_in,       // bias control bit
    input  wire logic       core_uv_warn_in,            // core supply uv warning
    input  wire logic       can_uv_warn_in,             // can supply uv warning
    input  wire logic       can_bus_wake_in,            // bus wake detected
    input  wire logic       local_wake_pin_a_in,        // wake pin a
    input  wire logic       local_wake_pin_b_in,        // wake pin b
    output logic            wake_bias_output_out,       // bias pin level
    output logic            wake_bias_output_oe_n_out,  // low while bias driven
    output logic [1:0]      can_xcvr_mode_out,          // off / active / low power
    output logic            can_bus_wake_det_en_out,    // bus wake detection on
    output logic            can_wake_flag_clear_out,    // hold can wake flag clear
    output logic            reset_threshold_select_out, // 0: 90 %, 1: 70 %
    output logic            irq_pending_out,            // any status flag set
    output logic            sleep_reset_out             // one-cycle reset request
);
    import sbc_int_wake_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // every pin goes through two flops; stage one feeds only stage two
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] prev_q;
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            // sck idles low and cs idles high, so no false edge follows reset
            sync1_q <= 8'h02;
            sync2_q <= 8'h02;
            prev_q  <= 8'h02;
        end else begin
            sync1_q <= {local_wake_pin_b_in, local_wake_pin_a_in, can_bus_wake_in,
                        can_uv_warn_in, core_uv_warn_in, spi_sdi_in, spi_cs_n_in, spi_sck_in};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    function automatic logic edge_hit(input logic [1:0] sel, input logic old_v,
                                      input logic new_v);
        unique case (sel)
            EDGE_OFF:  edge_hit = 1'b0;
            EDGE_RISE: edge_hit = new_v & ~old_v;
            EDGE_FALL: edge_hit = ~new_v & old_v;
            EDGE_BOTH: edge_hit = new_v ^ old_v;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // wake sampling, bias pulse and output decode
    logic [23:0] per_cnt_q, per_cnt_d;
    logic        samp_a_q, samp_a_d, samp_b_q, samp_b_d;
    logic        bias_q, bias_d;
    logic [1:0]  mode_prev_q;
    logic        sleep_rst_q, sleep_rst_d;
    logic [1:0]  can_mode_q, can_mode_d;
    logic        det_en_q, det_en_d, flag_clr_q, flag_clr_d, rth_q, rth_d;
    logic [15:0] ctrl_q, ctrl_d, stat_q, stat_d;
    logic        any_smp, smp_tick;
    logic [23:0] per_last;
    logic [15:0] set_vec;

    // one shared period counter: both pins see the same bias pulse
    always_comb begin
        any_smp  = ctrl_q[WAKE_A_SMP] | ctrl_q[WAKE_B_SMP];
        per_last = wake_bias_control_in ? 24'(LONG_PERIOD_CYC - 24'h000001)
                                        : 24'(SHORT_PERIOD_CYC - 24'h000001);
        per_cnt_d = 24'h000000;
        if (any_smp && per_cnt_q < per_last) begin
            per_cnt_d = 24'(per_cnt_q + 24'h000001);
        end
        // sample at the end of the bias window, when the pin has settled
        smp_tick = any_smp && (per_cnt_q == 24'(BIAS_ON_CYC - 24'h000001));
        samp_a_d = (!ctrl_q[WAKE_A_SMP] || smp_tick) ? sync2_q[SY_WAKE_A] : samp_a_q;
        samp_b_d = (!ctrl_q[WAKE_B_SMP] || smp_tick) ? sync2_q[SY_WAKE_B] : samp_b_q;
        // idle bias: floating with control 0, low with control 1
        bias_d = any_smp ? (per_cnt_q < BIAS_ON_CYC) : wake_bias_control_in;
        // mode field bit 1 set means a Normal mode
        if (ctrl_q[CAN_LP_BIT]) begin
            can_mode_d = CAN_LOWPOWER;
            det_en_d   = 1'b1;
            flag_clr_d = 1'b0;
        end else if (chip_mode_field_in[1]) begin
            can_mode_d = CAN_ACTIVE;
            det_en_d   = 1'b0;
            flag_clr_d = 1'b1;
        end else begin
            can_mode_d = CAN_OFF;
            det_en_d   = 1'b0;
            flag_clr_d = 1'b0;
        end
        rth_d = ctrl_q[RTH_BIT];
        sleep_rst_d = (chip_mode_field_in == MODE_SLEEP) && (mode_prev_q != MODE_SLEEP)
                    && !ctrl_q[CAN_LP_BIT]
                    && (ctrl_q[WAKE_A_SEL+:2] == EDGE_OFF)
                    && (ctrl_q[WAKE_B_SEL+:2] == EDGE_OFF);
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            per_cnt_q   <= 24'h000000;
            samp_a_q    <= 1'b0;
            samp_b_q    <= 1'b0;
            bias_q      <= 1'b0;
            mode_prev_q <= MODE_STANDBY;
            sleep_rst_q <= 1'b0;
            can_mode_q  <= CAN_OFF;
            det_en_q    <= 1'b0;
            flag_clr_q  <= 1'b0;
            rth_q       <= 1'b0;
        end else begin
            per_cnt_q   <= per_cnt_d;
            samp_a_q    <= samp_a_d;
            samp_b_q    <= samp_b_d;
            bias_q      <= bias_d;
            mode_prev_q <= chip_mode_field_in;
            sleep_rst_q <= sleep_rst_d;
            can_mode_q  <= can_mode_d;
            det_en_q    <= det_en_d;
            flag_clr_q  <= flag_clr_d;
            rth_q       <= rth_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // spi frame: 3 address bits, access bit, 12 data bits, msb first
    logic [4:0]  bit_cnt_q, bit_cnt_d;
    logic [15:0] rx_q, rx_d, tx_q, tx_d;
    logic        sdo_q, sdo_d;
    logic        sck_rise, sck_fall, cs_fall, cs_rise, commit;
    logic [15:0] rd_word;

    always_comb begin
        sck_rise = sync2_q[SY_SCK] & ~prev_q[SY_SCK];
        sck_fall = ~sync2_q[SY_SCK] & prev_q[SY_SCK];
        cs_fall  = ~sync2_q[SY_CS] & prev_q[SY_CS];
        cs_rise  = sync2_q[SY_CS] & ~prev_q[SY_CS];
        // events set flags; the uv and can flags are gated by their enables
        set_vec = 16'h0000;
        set_vec[ST_CORE_UV]  = ctrl_q[CORE_UV_EN]
                             & sync2_q[SY_CORE_UV] & ~prev_q[SY_CORE_UV];
        set_vec[ST_CAN_UV]   = ctrl_q[CAN_UV_EN]
                             & sync2_q[SY_CAN_UV] & ~prev_q[SY_CAN_UV];
        set_vec[ST_CAN_WAKE] = ctrl_q[CAN_LP_BIT]
                             & sync2_q[SY_CAN_WAKE] & ~prev_q[SY_CAN_WAKE];
        set_vec[ST_WAKE_A]   = edge_hit(ctrl_q[WAKE_A_SEL+:2], samp_a_q, samp_a_d);
        set_vec[ST_WAKE_B]   = edge_hit(ctrl_q[WAKE_B_SEL+:2], samp_b_q, samp_b_d);
        rd_word = 16'h0000;
        if (rx_q[2:0] == ADDR_INT_CTRL) begin
            rd_word = ctrl_q;
        end else if (rx_q[2:0] == ADDR_INT_STAT) begin
            rd_word = stat_q;
        end
        bit_cnt_d = bit_cnt_q;
        rx_d      = rx_q;
        tx_d      = tx_q;
        if (cs_fall) begin
            bit_cnt_d = 5'h00;
            tx_d      = 16'h0000;
        end else if (!sync2_q[SY_CS] && sck_rise && bit_cnt_q < SPI_BITS_C) begin
            rx_d      = {rx_q[14:0], sync2_q[SY_SDI]};
            bit_cnt_d = 5'(bit_cnt_q + 5'h01);
        end else if (!sync2_q[SY_CS] && sck_fall) begin
            // once the address is in, send the addressed word's lower bits
            tx_d = (bit_cnt_q == ADDR_BITS_C) ? {rd_word[12:0], 3'h0} : {tx_q[14:0], 1'b0};
        end
        sdo_d  = tx_d[15];
        // short or aborted frames change nothing
        commit = cs_rise && (bit_cnt_q == SPI_BITS_C) && !rx_q[RO_BIT];
        ctrl_d = ctrl_q;
        stat_d = stat_q | set_vec;
        if (commit && rx_q[15:13] == ADDR_INT_CTRL) begin
            ctrl_d = rx_q & CTRL_WMASK;
        end
        if (commit && rx_q[15:13] == ADDR_INT_STAT) begin
            // a set in the same cycle beats the clear
            stat_d = (stat_q & ~(rx_q & STAT_MASK)) | set_vec;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            bit_cnt_q <= 5'h00;
            rx_q      <= 16'h0000;
            tx_q      <= 16'h0000;
            sdo_q     <= 1'b0;
            ctrl_q    <= CTRL_RESET;
            stat_q    <= STAT_RESET;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            rx_q      <= rx_d;
            tx_q      <= tx_d;
            sdo_q     <= sdo_d;
            ctrl_q    <= ctrl_d;
            stat_q    <= stat_d;
        end
    end

    assign spi_sdo_out                = sdo_q;
    assign spi_sdo_oe_n_out           = sync2_q[SY_CS];   // released between frames
    assign wake_bias_output_out       = 1'b0;             // bias only ever pulls low
    assign wake_bias_output_oe_n_out  = ~bias_q;
    assign can_xcvr_mode_out          = can_mode_q;
    assign can_bus_wake_det_en_out    = det_en_q;
    assign can_wake_flag_clear_out    = flag_clr_q;
    assign reset_threshold_select_out = rth_q;
    assign irq_pending_out            = |stat_q;
    assign sleep_reset_out            = sleep_rst_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_ro_frame;
        cs_rise && bit_cnt_q == SPI_BITS_C && rx_q[RO_BIT];
    endsequence
    sequence s_stat_clear(int b);
        commit && rx_q[15:13] == ADDR_INT_STAT && rx_q[b] && !set_vec[b];
    endsequence

    a_ro_holds_ctrl: assert property (s_ro_frame |=> $stable(ctrl_q))
        else $error("read-only frame changed control");
    a_core_uv_gate: assert property ($rose(stat_q[ST_CORE_UV])
        |-> $past(ctrl_q[CORE_UV_EN]))
        else $error("core uv flag set while disabled");
    a_can_uv_gate: assert property ($rose(stat_q[ST_CAN_UV]) |-> $past(ctrl_q[CAN_UV_EN]))
        else $error("can uv flag set while disabled");
    a_wake_a_sel: assert property ($rose(stat_q[ST_WAKE_A])
        |-> $past(ctrl_q[WAKE_A_SEL+:2]) != EDGE_OFF)
        else $error("wake a flag set while disabled");
    a_wake_b_sel: assert property ($rose(stat_q[ST_WAKE_B])
        |-> $past(ctrl_q[WAKE_B_SEL+:2]) != EDGE_OFF)
        else $error("wake b flag set while disabled");
    a_can_active: assert property (!ctrl_q[CAN_LP_BIT] && chip_mode_field_in[1]
        |=> can_xcvr_mode_out == CAN_ACTIVE && can_wake_flag_clear_out)
        else $error("can not active in normal");
    // the wake gate is judged in the same cycle, since a write may set low power next
    a_can_off: assert property (!ctrl_q[CAN_LP_BIT] && !chip_mode_field_in[1]
        |-> !set_vec[ST_CAN_WAKE]
        ##1 (can_xcvr_mode_out == CAN_OFF && !can_bus_wake_det_en_out))
        else $error("can not off in standby or sleep");
    a_can_lowpower: assert property (ctrl_q[CAN_LP_BIT]
        |=> can_xcvr_mode_out == CAN_LOWPOWER && can_bus_wake_det_en_out)
        else $error("can not in low power");
    a_rth_follows: assert property ($changed(ctrl_q[RTH_BIT])
        |=> reset_threshold_select_out == $past(ctrl_q[RTH_BIT]))
        else $error("threshold select lagging");
    a_period_wrap: assert property (any_smp && per_cnt_q == per_last
        |=> per_cnt_q == 24'h000000)
        else $error("sample period did not wrap");
    a_period_bound: assert property (per_cnt_q <= 24'(LONG_PERIOD_CYC - 24'h000001))
        else $error("sample period overrun");
    a_stat_clear_a: assert property (s_stat_clear(ST_WAKE_A) |=> !stat_q[ST_WAKE_A])
        else $error("wake a flag not cleared");
    a_flag_sticky: assert property (stat_q[ST_WAKE_B] && !commit |=> stat_q[ST_WAKE_B])
        else $error("wake b flag dropped");
    a_sleep_reset: assert property ($rose(sleep_reset_out)
        |-> $past(chip_mode_field_in) == MODE_SLEEP
            && $past(ctrl_q[WAKE_A_SEL+1:CAN_LP_BIT]) == 5'h00)
        else $error("sleep reset without cause");
endmodule
`default_nettype wire

// *** test/spi_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    input  wire logic        ref_clk_in,  // bench clock, paces each frame
    input  wire logic        sdo_in,      // device data out
    output logic             sck_out,     // spi clock, stands low outside frames
    output logic             cs_n_out,    // select, low active
    output logic             sdi_out,     // data to the device
    output logic             rx_stb_out,  // one cycle when a read word is ready
    output logic [15:0]      rx_word_out  // word shifted in during the last read frame
);
    // six clocks per half period keeps above the four-clock floor with margin
    localparam int HALF = 6;
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
        rx_stb_out = 1'b0;
        rx_word_out = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    // whole 16-bit frame, msb first; data set while sck low, sdo taken at the rise
    task automatic xfer(input logic [15:0] tx);
        logic [15:0] rx;
        rx = 16'h0000;
        cs_n_out = 1'b0;
        wait_clk(HALF);
        for (int i = 15; i >= 0; i--) begin
            sdi_out = tx[i];
            wait_clk(HALF);
            sck_out = 1'b1;
            rx[i] = sdo_in;
            wait_clk(HALF);
            sck_out = 1'b0;
        end
        wait_clk(HALF);
        cs_n_out = 1'b1;
        sdi_out = ~sdi_out; // released line: no pull, so never leave the last bit showing
        if (tx[12]) begin
            rx_word_out = rx;
            rx_stb_out = 1'b1;
            wait_clk(1);
            rx_stb_out = 1'b0;
        end
        wait_clk(HALF);
    endtask
endmodule
`default_nettype wire

// *** test/sbc_interrupt_wake_control_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module sbc_interrupt_wake_control_bench;
    import sbc_int_wake_pkg::*;
    // shortened sampling periods keep the run brief; both stay above the bias window
    localparam logic [23:0] SHORT_C = 24'h0007d0;
    localparam logic [23:0] LONG_C  = 24'h000fa0;
    logic        ref_clk, reset, sck, cs_n, sdi, sdo, sdo_oe_n, bias_ctl;
    logic        core_uv, can_uv, bus_wake, pin_a, pin_b, bias, bias_oe_n;
    logic        det_en, flag_clr, rth_sel, irq, sleep_rst, rx_stb;
    logic [1:0]  mode, xcvr_mode;
    logic [15:0] rx_word, v, m;
    logic [31:0] lfsr_q;
    logic [15:0] expect_q[$];
    int          num_errors = 0;
    int          comparisons = 0;
    int          sleep_cnt = 0;
    int          low, per;
    ////////////////////////////////////////////////////////////////////////////
    sbc_interrupt_wake_control #(.SHORT_PERIOD_CYC(SHORT_C), .LONG_PERIOD_CYC(LONG_C))
        sbc_interrupt_wake_control_i (
        .ref_clk_in(ref_clk), .reset_in(reset), .spi_sck_in(sck), .spi_cs_n_in(cs_n),
        .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_n_out(sdo_oe_n),
        .chip_mode_field_in(mode), .wake_bias_control_in(bias_ctl),
        .core_uv_warn_in(core_uv), .can_uv_warn_in(can_uv), .can_bus_wake_in(bus_wake),
        .local_wake_pin_a_in(pin_a), .local_wake_pin_b_in(pin_b),
        .wake_bias_output_out(bias), .wake_bias_output_oe_n_out(bias_oe_n),
        .can_xcvr_mode_out(xcvr_mode), .can_bus_wake_det_en_out(det_en),
        .can_wake_flag_clear_out(flag_clr), .reset_threshold_select_out(rth_sel),
        .irq_pending_out(irq), .sleep_reset_out(sleep_rst));
    spi_host_model spi_host_model_i (
        .ref_clk_in(ref_clk), .sdo_in(sdo), .sck_out(sck), .cs_n_out(cs_n),
        .sdi_out(sdi), .rx_stb_out(rx_stb), .rx_word_out(rx_word));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [11:0] d);
        spi_host_model_i.xfer({a, 1'b0, d});
        cyc(6);
    endtask
    // a read-only frame also carries data bits; the answer is noted before it starts
    task automatic rdx(input logic [2:0] a, input logic [11:0] d, input logic [15:0] exp);
        expect_q.push_back(exp);
        spi_host_model_i.xfer({a, 1'b1, d});
        cyc(6);
    endtask
    task automatic wrap_up();
        // a read answer that never arrived counts as a mismatch
        num_errors = num_errors + expect_q.size();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // read answers are matched in order against the oldest note
    always @(posedge ref_clk) begin
        if (rx_stb === 1'b1) begin
            if (expect_q.size() == 0) check(rx_word, 16'hdead);
            else check(rx_word, expect_q.pop_front());
        end
        if (sleep_rst === 1'b1) sleep_cnt++;
    end
    initial begin
        repeat (80000) @(posedge ref_clk);
        num_errors++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset, mode, bias_ctl, core_uv, can_uv, bus_wake, pin_a, pin_b} = 9'h100;
        lfsr_q = 32'h3357;
        cyc(20);
        reset = 1'b0;
        cyc(4);
        check(16'(xcvr_mode), 16'(CAN_OFF));
        check(16'({sdo_oe_n, bias}), 16'h0002);
        rdx(ADDR_INT_CTRL, 12'h000, CTRL_RESET);
        rdx(ADDR_INT_STAT, 12'h000, STAT_RESET);
        // random writes, then read-only and unmapped frames must leave them alone
        for (int k = 0; k < 4; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            v = {4'h0, lfsr_q[11:0]} & CTRL_WMASK;
            wr(ADDR_INT_CTRL, lfsr_q[11:0]);
            check(16'(rth_sel), 16'(v[RTH_BIT]));
            rdx(ADDR_INT_CTRL, ~lfsr_q[11:0], v);
            rdx(3'h5, 12'hfff, 16'h0000);
            rdx(ADDR_INT_CTRL, 12'h000, v);
        end
        // transceiver behaviour over every mode code and both low-power settings
        for (int lp = 0; lp < 2; lp++) begin
            for (int md = 0; md < 4; md++) begin
                wr(ADDR_INT_CTRL, 12'(lp << CAN_LP_BIT));
                mode = 2'(md);
                cyc(3);
                v = 16'(lp ? CAN_LOWPOWER : (md > 1) ? CAN_ACTIVE : CAN_OFF);
                check(16'(xcvr_mode), v);
                check(16'(det_en), 16'(lp));
                check(16'(flag_clr), 16'(lp == 0 && md > 1));
                mode = 2'h0;
            end
        end
        wr(ADDR_INT_CTRL, 12'h040);
        mode = MODE_SLEEP;
        cyc(4);
        mode = MODE_STANDBY;
        check(16'(sleep_cnt), 16'h0001);
        // undervoltage events with enables off, then on
        for (int en = 0; en < 2; en++) begin
            wr(ADDR_INT_CTRL, en ? 12'hc00 : 12'h000);
            {core_uv, can_uv} = 2'h3;
            cyc(10);
            check(16'(irq), 16'(en));
            {core_uv, can_uv} = 2'h0;
            rdx(ADDR_INT_STAT, 12'h000, en ? 16'h0c00 : 16'h0000);
            wr(ADDR_INT_STAT, 12'hc00);
            rdx(ADDR_INT_STAT, 12'h000, 16'h0000);
        end
        // every edge code on both pins, rise and fall judged separately
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                m = p ? 16'h0010 : 16'h0040;
                wr(ADDR_INT_CTRL, 12'(c << (p ? WAKE_B_SEL : WAKE_A_SEL)));
                {pin_b, pin_a} = p ? 2'h2 : 2'h1;
                cyc(10);
                rdx(ADDR_INT_STAT, 12'h000, c[0] ? m : 16'h0000);
                wr(ADDR_INT_STAT, 12'h050);
                {pin_b, pin_a} = 2'h0;
                cyc(10);
                rdx(ADDR_INT_STAT, 12'h000, c[1] ? m : 16'h0000);
                wr(ADDR_INT_STAT, 12'h050);
            end
        end
        // bus wake only raises its flag while low-power control is set
        for (int lp = 0; lp < 2; lp++) begin
            wr(ADDR_INT_CTRL, 12'(lp << CAN_LP_BIT));
            bus_wake = 1'b1;
            cyc(10);
            bus_wake = 1'b0;
            rdx(ADDR_INT_STAT, 12'h000, lp ? 16'h0008 : 16'h0000);
            wr(ADDR_INT_STAT, 12'h008);
        end
        // synchronised sampling: bias window length and period per bias control
        for (int b = 0; b < 2; b++) begin
            bias_ctl = 1'(b);
            wr(ADDR_INT_CTRL, b ? 12'h001 : 12'h002);
            low = 0;
            per = 0;
            while (bias_oe_n !== 1'b1 && per < 9000) begin
                cyc(1);
                per++;
            end
            while (bias_oe_n !== 1'b0 && per < 18000) begin
                cyc(1);
                per++;
            end
            per = 0;
            while (bias_oe_n === 1'b0 && per < 9000) begin
                cyc(1);
                low++;
                per++;
            end
            while (bias_oe_n === 1'b1 && per < 9000) begin
                cyc(1);
                per++;
            end
            check(16'(low), BIAS_ON_CYC[15:0]);
            check(16'(per), b ? LONG_C[15:0] : SHORT_C[15:0]);
        end
        wr(ADDR_INT_CTRL, 12'h000);
        cyc(3);
        check(16'(bias_oe_n), 16'h0000);
        cyc(10);
        wrap_up();
    end
endmodule
`default_nettype wire
